// ==== core/mps_host.sv ====
// flash controller end: register-driven multi-plane command sequences
`timescale 1ns/1ns
`include "mps_defines.svh"
module mps_host
	import mps_pkg::*;
#(
	parameter int PLANES = 2,
	parameter int PAGE_BITS = 6,
	parameter int ADDR_W = 8
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	mps_if.host lk,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam int PW = $clog2(PLANES);

	if (PLANES < 2 || PLANES > `MPS_MAX_PLANES || ADDR_W < 5 || PAGE_BITS + PW > 23)
	begin : g_chk
		$error("mps_host: unsupported PLANES, PAGE_BITS or ADDR_W");
	end

	typedef struct packed {
		mps_hst_t st;
		logic ph;
		logic [3:0] m;
		logic [7:0] cnt;
		logic [31:0] ctrl;
		logic [23:0] row;
		logic [15:0] col;
		logic [7:0] dat;
		logic busy;
		logic done;
		logic err;
		logic [PLANES-1:0][7:0] sstat;
		logic cle;
		logic ale;
		logic we;
		logic [7:0] dq;
		logic awready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} mps_host_s_t;

	mps_host_s_t q;
	mps_host_s_t d;

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++)
			if (s[i])
				r[8*i +: 8] = n[8*i +: 8];
		return r;
	endfunction

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		return (a >> 5) == '0 && a[1:0] == 2'b00 && a[4:2] <= 3'd5;
	endfunction

	logic [2:0] op;
	logic [3:0] npl;
	logic [7:0] ndata;
	logic lastm;
	logic [23:0] mrow;
	logic [7:0] first_cmd;
	logic [7:0] conf_cmd;
	logic [7:0] abyte;

	assign op = q.ctrl[`MPS_CTRL_OP +: 3];
	assign npl = q.ctrl[`MPS_CTRL_NPL +: 4];
	assign ndata = q.ctrl[`MPS_CTRL_NDATA +: 8];
	assign lastm = q.m == npl - 4'd1;

	always_comb
	begin
		// plane bits replaced by member index; unit bits kept
		mrow = q.row;
		mrow[PAGE_BITS +: PW] = q.m[PW-1:0];
		// column bytes then row bytes, LSB first
		case (q.cnt[2:0])
		3'd0:
			abyte = q.col[7:0];
		3'd1:
			abyte = q.col[15:8];
		3'd2:
			abyte = mrow[7:0];
		3'd3:
			abyte = mrow[15:8];
		default:
			abyte = mrow[23:16];
		endcase
		// legacy first cycle, 81h for later members if chosen
		case (op)
		// copyback reads go one plane at a time
		`MPS_HOP_CB:
			first_cmd = !q.ph ? `MPS_CMD_READ
				: (q.m != 4'd0 && q.ctrl[`MPS_CTRL_ALT]) ? `MPS_CMD_ALT : `MPS_CMD_CBPROG;
		`MPS_HOP_ERASE:
			first_cmd = `MPS_CMD_ERASE;
		`MPS_HOP_READ:
			first_cmd = `MPS_CMD_READ;
		default:
			first_cmd = (q.m != 4'd0 && q.ctrl[`MPS_CTRL_ALT]) ? `MPS_CMD_ALT : `MPS_CMD_PROG;
		endcase
		// intermediate confirm for all but the last member, outside copyback reads
		case (op)
		`MPS_HOP_ERASE:
			conf_cmd = lastm ? `MPS_CMD_ECONF : `MPS_CMD_EMP;
		`MPS_HOP_READ:
			conf_cmd = !lastm ? `MPS_CMD_RMP
				: q.ctrl[`MPS_CTRL_CACHE] ? `MPS_CMD_RCACHE : `MPS_CMD_RCONF;
		default:
			// cache close only when software asks for it
			conf_cmd = (op == `MPS_HOP_CB && !q.ph) ? `MPS_CMD_CBRCONF
				: !lastm ? `MPS_CMD_MPCONF
				: q.ctrl[`MPS_CTRL_CACHE] ? `MPS_CMD_CCONF : `MPS_CMD_PCONF;
		endcase
	end

	always_comb
	begin
		d = q;
		if (ce)
		begin
			d.cle = 1'b0;
			d.ale = 1'b0;
			d.we = 1'b0;
			d.awready = 1'b0;
			d.arready = 1'b0;
			case (q.st)
			MPS_HS_CMD:
			begin
				d.cle = 1'b1;
				d.we = 1'b1;
				d.dq = first_cmd;
				d.cnt = op == `MPS_HOP_ERASE ? 8'd2 : 8'd0;
				d.st = MPS_HS_ADDR;
			end
			MPS_HS_ADDR:
			begin
				d.ale = 1'b1;
				d.we = 1'b1;
				d.dq = abyte;
				d.cnt = q.cnt + 8'd1;
				if (q.cnt == 8'd4)
				begin
					d.cnt = 8'd0;
					d.st = (op == `MPS_HOP_PROG && ndata != 8'd0) ? MPS_HS_DATA : MPS_HS_CONF;
				end
			end
			MPS_HS_DATA:
			begin
				d.we = 1'b1;
				d.dq = q.dat + q.cnt;
				d.cnt = q.cnt + 8'd1;
				if (q.cnt == ndata - 8'd1)
					d.st = MPS_HS_CONF;
			end
			MPS_HS_CONF:
			begin
				d.cle = 1'b1;
				d.we = 1'b1;
				d.dq = conf_cmd;
				d.cnt = 8'd1;
				d.st = MPS_HS_WAIT;
			end
			MPS_HS_WAIT:
			begin
				// one dead cycle: ready drops a cycle after the confirm
				if (q.cnt != 8'd0)
					d.cnt = 8'd0;
				else if (lk.rdy)
				begin
					d.m = q.m + 4'd1;
					d.st = MPS_HS_CMD;
					if (lastm)
					begin
						d.m = 4'd0;
						// copyback reads cover the same planes as the program
						if (!q.ph)
							d.ph = 1'b1;
						else
						begin
							d.st = MPS_HS_IDLE;
							d.busy = 1'b0;
							d.done = 1'b1;
							d.sstat = lk.status;
						end
					end
				end
			end
			default:
				d.st = MPS_HS_IDLE;
			endcase
			// write channel: address and data taken together
			if (s_axi_awvalid && s_axi_wvalid && !q.bvalid && !q.awready)
				d.awready = 1'b1;
			if (q.awready)
			begin
				d.bvalid = 1'b1;
				d.bresp = mapped(s_axi_awaddr) ? 2'b00 : 2'b10;
				case (s_axi_awaddr[4:0])
				`MPS_OFF_CTRL:
				begin
					d.ctrl = merge(q.ctrl, s_axi_wdata, s_axi_wstrb);
					d.ctrl[`MPS_CTRL_GO] = 1'b0;
					if (d.ctrl != q.ctrl && q.busy)
						d.ctrl = q.ctrl;
					if (s_axi_wstrb[0] && s_axi_wdata[`MPS_CTRL_GO] && !q.busy
						&& mapped(s_axi_awaddr))
					begin
						// one kind per run; one member per plane
						if (d.ctrl[`MPS_CTRL_OP +: 3] inside {[`MPS_HOP_PROG:`MPS_HOP_READ]}
							&& d.ctrl[`MPS_CTRL_NPL +: 4] != 4'd0
							&& d.ctrl[`MPS_CTRL_NPL +: 4] <= 4'(PLANES))
						begin
							d.busy = 1'b1;
							d.done = 1'b0;
							d.err = 1'b0;
							d.m = 4'd0;
							d.ph = d.ctrl[`MPS_CTRL_OP +: 3] != `MPS_HOP_CB;
							d.st = MPS_HS_CMD;
						end
						else
							d.err = 1'b1;
					end
				end
				`MPS_OFF_ROW:
					if (!q.busy)
						d.row = 24'(merge({8'h00, q.row}, s_axi_wdata, s_axi_wstrb));
				`MPS_OFF_COL:
					if (!q.busy)
						d.col = 16'(merge({16'h0000, q.col}, s_axi_wdata, s_axi_wstrb));
				`MPS_OFF_DATA:
					if (!q.busy)
						d.dat = 8'(merge({24'h00_0000, q.dat}, s_axi_wdata, s_axi_wstrb));
				default:
					;
				endcase
			end
			if (q.bvalid && s_axi_bready)
				d.bvalid = 1'b0;
			if (s_axi_arvalid && !q.rvalid && !q.arready)
				d.arready = 1'b1;
			if (q.arready)
			begin
				d.rvalid = 1'b1;
				d.rresp = mapped(s_axi_araddr) ? 2'b00 : 2'b10;
				d.rdata = 32'h0000_0000;
				if (mapped(s_axi_araddr))
				begin
					case (s_axi_araddr[4:0])
					`MPS_OFF_CTRL:
						d.rdata = q.ctrl;
					`MPS_OFF_ROW:
						d.rdata = {8'h00, q.row};
					`MPS_OFF_COL:
						d.rdata = {16'h0000, q.col};
					`MPS_OFF_DATA:
						d.rdata = {24'h00_0000, q.dat};
					`MPS_OFF_STAT:
						d.rdata = {29'h0, q.err, q.done, q.busy};
					default:
						d.rdata = 32'(q.sstat);
					endcase
				end
			end
			if (q.rvalid && s_axi_rready)
				d.rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			q <= '0;
			q.ctrl <= `MPS_CTRL_RST;
			q.row <= `MPS_ROW_RST;
		end
		else
			q <= d;
	end

	assign lk.cle = q.cle;
	assign lk.ale = q.ale;
	assign lk.we = q.we;
	assign lk.dq = q.dq;
	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.awready;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
endmodule

// ==== pkg/mps_defines.svh ====
// constants for the multi-plane operation sequencer
`ifndef MPS_DEFINES_SVH
`define MPS_DEFINES_SVH

// command cycles
`define MPS_CMD_PROG 8'h80
`define MPS_CMD_ALT 8'h81
`define MPS_CMD_CBPROG 8'h85
`define MPS_CMD_MPCONF 8'h11
`define MPS_CMD_PCONF 8'h10
`define MPS_CMD_CCONF 8'h15
`define MPS_CMD_ERASE 8'h60
`define MPS_CMD_EMP 8'hd1
`define MPS_CMD_ECONF 8'hd0
`define MPS_CMD_READ 8'h00
`define MPS_CMD_RMP 8'h32
`define MPS_CMD_RCONF 8'h30
`define MPS_CMD_RCACHE 8'h31
`define MPS_CMD_CBRCONF 8'h35

// status byte bit positions
`define MPS_SR_FAIL 0
`define MPS_SR_PREVIOUS_OP_FAIL_FLAG 1
`define MPS_SR_VSP 4
`define MPS_SR_ARRAY_READY_FLAG 5
`define MPS_SR_RDY 6
`define MPS_SR_WP 7

// timing
`define MPS_CLK_NS 8
`define MPS_T_SBSY_NS 500

// controller register offsets
`define MPS_OFF_CTRL 5'h00
`define MPS_OFF_ROW 5'h04
`define MPS_OFF_COL 5'h08
`define MPS_OFF_DATA 5'h0c
`define MPS_OFF_STAT 5'h10
`define MPS_OFF_PSTAT 5'h14

// control field positions
`define MPS_CTRL_GO 0
`define MPS_CTRL_OP 1
`define MPS_CTRL_CACHE 4
`define MPS_CTRL_ALT 5
`define MPS_CTRL_NPL 8
`define MPS_CTRL_NDATA 16

// operation codes in the control register
`define MPS_HOP_PROG 3'h1
`define MPS_HOP_CB 3'h2
`define MPS_HOP_ERASE 3'h3
`define MPS_HOP_READ 3'h4

// reset values and plane limit
`define MPS_CTRL_RST 32'h0004_0202
`define MPS_ROW_RST 24'h00_0000
`define MPS_MAX_PLANES 4

`endif

// ==== pkg/mps_pkg.sv ====
// types shared by both ends of the multi-plane sequencer
package mps_pkg;

	typedef enum logic [2:0] {
		MPS_OP_NONE,
		MPS_OP_PROG,
		MPS_OP_CBREAD,
		MPS_OP_CBPROG,
		MPS_OP_ERASE,
		MPS_OP_READ
	} mps_op_t;

	typedef enum logic [1:0] {
		MPS_DS_IDLE,
		MPS_DS_ADDR,
		MPS_DS_DATA,
		MPS_DS_WAIT
	} mps_dst_t;

	typedef enum logic [2:0] {
		MPS_HS_IDLE,
		MPS_HS_CMD,
		MPS_HS_ADDR,
		MPS_HS_DATA,
		MPS_HS_CONF,
		MPS_HS_WAIT
	} mps_hst_t;

endpackage

// ==== pkg/mps_if.sv ====
// byte link between the flash controller and the flash unit
`timescale 1ns/1ns
interface mps_if #(
	parameter int PLANES = 2
);
	logic cle;
	logic ale;
	logic we;
	logic [7:0] dq;
	logic rdy;
	logic [PLANES-1:0][7:0] status;

	modport dev (
		input cle,
		input ale,
		input we,
		input dq,
		output rdy,
		output status
	);

	modport host (
		output cle,
		output ale,
		output we,
		output dq,
		input rdy,
		input status
	);
endinterface

// ==== core/mps_device.sv ====
// flash unit end: multi-plane command decode, array launch, status
`timescale 1ns/1ns
`include "mps_defines.svh"
module mps_device
	import mps_pkg::*;
#(
	parameter int PLANES = 2,
	parameter int PAGE_BITS = 6,
	parameter int T_SBSY_NS = `MPS_T_SBSY_NS
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	mps_if.dev lk,
	input wire logic cfg_overlap,
	input wire logic cfg_alt81,
	input wire logic cfg_cache,
	input wire logic cfg_same_blk,
	input wire logic cfg_same_page,
	input wire logic wp_n,
	input wire logic [PLANES-1:0] arr_done,
	input wire logic [PLANES-1:0] arr_fail,
	output logic [PLANES-1:0] arr_go,
	output mps_op_t arr_op,
	output logic [PLANES-1:0][23:0] arr_row,
	output logic pg_wr,
	output logic [$clog2(PLANES)-1:0] pg_plane,
	output logic [15:0] pg_col,
	output logic [7:0] pg_data,
	output logic seq_err
);
	localparam int PW = $clog2(PLANES);
	localparam int SBSY_CYC = (T_SBSY_NS + `MPS_CLK_NS - 1) / `MPS_CLK_NS;
	localparam int SBW = $clog2(SBSY_CYC + 1);

	if (PLANES < 2 || PLANES > `MPS_MAX_PLANES || PAGE_BITS < 1 || PAGE_BITS + PW > 23)
	begin : g_chk
		$error("mps_device: unsupported PLANES or PAGE_BITS");
	end

	typedef struct packed {
		mps_dst_t st;
		mps_op_t op;
		logic first;
		logic [2:0] acnt;
		logic [23:0] row;
		logic [15:0] col;
		logic [23:0] ref_row;
		logic [PLANES-1:0] used;
		logic [PLANES-1:0] pend;
		logic [PLANES-1:0] act;
		logic [PLANES-1:0] pe;
		logic [PLANES-1:0] fail;
		logic [PLANES-1:0] previous_op_fail_flag;
		logic [SBW-1:0] sbsy;
		logic hold;
		logic rdy;
		logic [PLANES-1:0][7:0] stat;
		logic [PLANES-1:0] go;
		mps_op_t go_op;
		logic [PLANES-1:0][23:0] arow;
		logic pg_wr;
		logic [PW-1:0] pg_plane;
		logic [15:0] pg_col;
		logic [7:0] pg_data;
		logic err;
	} mps_dev_s_t;

	mps_dev_s_t q;
	mps_dev_s_t d;

	function automatic logic [PW-1:0] plane_of(input logic [23:0] r);
		return r[PAGE_BITS +: PW];
	endfunction

	function automatic logic [23:0] blk_hi(input logic [23:0] r);
		return r >> (PAGE_BITS + PW);
	endfunction

	function automatic logic writes_array(input mps_op_t o);
		return o == MPS_OP_PROG || o == MPS_OP_CBPROG || o == MPS_OP_ERASE;
	endfunction

	always_comb
	begin
		logic mid;
		logic fin;
		logic cbr;
		logic bad;
		logic [PW-1:0] pl;
		logic [PLANES-1:0] lm;
		mps_op_t kind;
		mid = 1'b0;
		fin = 1'b0;
		cbr = 1'b0;
		bad = 1'b0;
		pl = plane_of(q.row);
		lm = '0;
		kind = q.op;
		d = q;
		if (ce)
		begin
			d.go = '0;
			d.pg_wr = 1'b0;
			d.err = 1'b0;
			if (q.sbsy != '0)
				d.sbsy = q.sbsy - 1'b1;
			if (lk.we && q.rdy && lk.cle)
			begin
				// only the four grouped functions decode
				case (lk.dq)
				`MPS_CMD_PROG:
					kind = MPS_OP_PROG;
				`MPS_CMD_CBPROG:
					kind = MPS_OP_CBPROG;
				`MPS_CMD_ERASE:
					kind = MPS_OP_ERASE;
				`MPS_CMD_READ:
					kind = MPS_OP_READ;
				// 81h only for later members when enabled
				`MPS_CMD_ALT:
					bad = q.first || !cfg_alt81 || !(q.op inside {MPS_OP_PROG, MPS_OP_CBPROG});
				// intermediate confirm keeps the group open
				`MPS_CMD_MPCONF:
					mid = q.op inside {MPS_OP_PROG, MPS_OP_CBPROG};
				`MPS_CMD_PCONF:
					fin = q.op inside {MPS_OP_PROG, MPS_OP_CBPROG};
				`MPS_CMD_CCONF:
				begin
					// refused close abandons the group, nothing launches
					fin = q.op inside {MPS_OP_PROG, MPS_OP_CBPROG};
					bad = !cfg_cache;
				end
				`MPS_CMD_EMP:
					mid = q.op == MPS_OP_ERASE;
				`MPS_CMD_ECONF:
					fin = q.op == MPS_OP_ERASE;
				`MPS_CMD_RMP:
					mid = q.op == MPS_OP_READ;
				`MPS_CMD_RCONF:
					fin = q.op == MPS_OP_READ;
				`MPS_CMD_RCACHE:
				begin
					fin = q.op == MPS_OP_READ;
					bad = !cfg_cache;
				end
				`MPS_CMD_CBRCONF:
				begin
					fin = q.op == MPS_OP_READ;
					cbr = 1'b1;
				end
				default:
					;
				endcase
				if (lk.dq inside {`MPS_CMD_PROG, `MPS_CMD_CBPROG, `MPS_CMD_ERASE,
					`MPS_CMD_READ, `MPS_CMD_ALT})
				begin
					// a foreign kind inside a group is refused
					bad = bad || q.st != MPS_DS_IDLE || (!q.first && kind != q.op);
					d.err = bad;
					if (!bad)
					begin
						d.op = kind;
						d.st = MPS_DS_ADDR;
						d.acnt = (kind == MPS_OP_ERASE) ? 3'd2 : 3'd0;
						d.col = '0;
					end
				end
				else if ((mid || fin) && q.st inside {MPS_DS_DATA, MPS_DS_WAIT})
				begin
					// optional block and page match against first member
					bad = bad || q.used[pl]
						|| (!q.first && cfg_same_blk && blk_hi(q.row) != blk_hi(q.ref_row))
						|| (!q.first && cfg_same_page
							&& q.row[PAGE_BITS-1:0] != q.ref_row[PAGE_BITS-1:0]);
					d.st = MPS_DS_IDLE;
					d.err = bad;
					if (bad)
					begin
						d.used = '0;
						d.pend = '0;
						d.first = 1'b1;
					end
					else
					begin
						d.used[pl] = 1'b1;
						d.arow[pl] = q.row;
						d.first = 1'b0;
						if (q.first)
							d.ref_row = q.row;
						if (cfg_overlap)
							lm[pl] = 1'b1;
						// concurrent holds all until the final confirm
						else if (fin)
							lm = q.pend | (PLANES'(1) << pl);
						else
							d.pend[pl] = 1'b1;
						if (fin)
						begin
							d.used = '0;
							d.pend = '0;
							d.first = 1'b1;
							d.hold = 1'b1;
						end
						else
							d.sbsy = SBW'(SBSY_CYC);
						d.go = lm;
						d.go_op = cbr ? MPS_OP_CBREAD : q.op;
						for (int i = 0; i < PLANES; i++)
						begin
							if (lm[i])
							begin
								d.act[i] = 1'b1;
								d.pe[i] = writes_array(q.op);
								// per-plane fail history shifts on launch of a program, copyback program or erase
								if (writes_array(q.op))
								begin
									d.previous_op_fail_flag[i] = q.fail[i];
									d.fail[i] = 1'b0;
								end
							end
						end
					end
				end
				else
					d.err = mid || fin;
			end
			else if (lk.we && q.rdy && lk.ale && q.st == MPS_DS_ADDR)
			begin
				// column then row bytes, least significant first
				case (q.acnt)
				3'd0:
					d.col[7:0] = lk.dq;
				3'd1:
					d.col[15:8] = lk.dq;
				3'd2:
					d.row[7:0] = lk.dq;
				3'd3:
					d.row[15:8] = lk.dq;
				default:
					d.row[23:16] = lk.dq;
				endcase
				d.acnt = q.acnt + 3'd1;
				if (q.acnt == 3'd4)
					d.st = writes_array(q.op) && q.op != MPS_OP_ERASE ? MPS_DS_DATA : MPS_DS_WAIT;
			end
			else if (lk.we && q.rdy && q.st == MPS_DS_DATA)
			begin
				// data lands in page register from the column
				d.pg_wr = 1'b1;
				d.pg_plane = pl;
				d.pg_col = q.col;
				d.pg_data = lk.dq;
				d.col = q.col + 16'd1;
			end
			// completion applied after launch so a reported failure is kept
			for (int i = 0; i < PLANES; i++)
			begin
				if (arr_done[i] && q.act[i])
				begin
					d.act[i] = 1'b0;
					if (arr_fail[i] && q.pe[i])
						d.fail[i] = 1'b1;
				end
			end
			if (q.hold && q.act == '0 && q.go == '0)
				d.hold = 1'b0;
			d.rdy = d.sbsy == '0 && !d.hold;
			for (int i = 0; i < PLANES; i++)
			begin
				// shared bits; same split in both modes
				d.stat[i] = 8'h00;
				d.stat[i][`MPS_SR_WP] = wp_n;
				d.stat[i][`MPS_SR_RDY] = d.rdy;
				d.stat[i][`MPS_SR_ARRAY_READY_FLAG] = d.act == '0;
				d.stat[i][`MPS_SR_VSP] = 1'b0;
				// fail bits from this plane only
				d.stat[i][`MPS_SR_PREVIOUS_OP_FAIL_FLAG] = d.previous_op_fail_flag[i];
				d.stat[i][`MPS_SR_FAIL] = d.fail[i];
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			q <= '0;
			q.first <= 1'b1;
			q.rdy <= 1'b1;
		end
		else
			q <= d;
	end

	assign lk.rdy = q.rdy;
	assign lk.status = q.stat;
	assign arr_go = q.go;
	assign arr_op = q.go_op;
	assign arr_row = q.arow;
	assign pg_wr = q.pg_wr;
	assign pg_plane = q.pg_plane;
	assign pg_col = q.pg_col;
	assign pg_data = q.pg_data;
	assign seq_err = q.err;
endmodule

// ==== test/mps_link_chk.sv ====
// link assertions for the multi-plane sequencer
`timescale 1ns/1ns
`include "mps_defines.svh"
module mps_link_chk #(
	parameter int PLANES = 2
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic cle,
	input wire logic ale,
	input wire logic we,
	input wire logic [7:0] dq,
	input wire logic rdy,
	input wire logic [PLANES-1:0][7:0] status
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ----------------------------------------
	// command steps
	// ----------------------------------------
	sequence s_cmd(logic [7:0] c);
		we && cle && rdy && ce && dq == c;
	endsequence
	sequence s_pcmd;
		we && cle && rdy && ce && dq inside {`MPS_CMD_PROG, `MPS_CMD_ALT, `MPS_CMD_CBPROG};
	endsequence
	sequence s_conf;
		we && cle && rdy && ce && dq inside {`MPS_CMD_MPCONF, `MPS_CMD_PCONF,
			`MPS_CMD_CCONF, `MPS_CMD_ECONF, `MPS_CMD_EMP, `MPS_CMD_RCONF, `MPS_CMD_CBRCONF};
	endsequence
	a_prog_addr: assert property (s_pcmd |=> (we && ale && !cle)[*5])
		else $error("program command not followed by five address bytes");
	a_erase_addr: assert property (s_cmd(`MPS_CMD_ERASE) |=> (we && ale)[*3] ##1 (we && cle))
		else $error("erase command not followed by three row bytes and confirm");
	a_short_busy: assert property (s_cmd(`MPS_CMD_MPCONF) |=> !rdy ##[1:6] rdy)
		else $error("intermediate confirm busy missing or too long");
	a_final_busy: assert property (s_cmd(`MPS_CMD_PCONF) |=> !rdy[*2])
		else $error("final program confirm did not hold the unit busy");
	a_dead_cycle: assert property (s_conf |=> !we)
		else $error("strobe right after a confirm");
	a_host_waits: assert property (!rdy |-> !we)
		else $error("strobe while the unit is busy");
	a_cle_ale_excl: assert property (we |-> !(cle && ale))
		else $error("command and address qualifiers together");
	// shared bits are the same in the first and last plane bytes, in either mode
	a_shared_bits: assert property (status[0][7:2] == status[PLANES-1][7:2])
		else $error("shared status bits differ between planes");
	a_reserved_zero: assert property ($rose(rdy) |-> status[0][4:2] == 3'h0)
		else $error("vendor or reserved status bits not zero");
endmodule

// ==== test/multi_plane_op_sequencer_tb.sv ====
// self-checking bench: controller and flash unit joined over the link
`timescale 1ns/1ns
`include "mps_defines.svh"
module multi_plane_op_sequencer_tb
	import mps_pkg::*;
;
	logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, wp_n = 1'b1;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic cfg_overlap = 1'b0, cfg_alt81 = 1'b0, cfg_cache = 1'b0;
	logic cfg_same_blk = 1'b0, cfg_same_page = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, pg_wr, seq_err;
	logic [7:0] awaddr = 8'h0, araddr = 8'h0, pg_data, wr0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0] bresp, rresp, arr_go, arr_done = 2'h0, arr_fail = 2'h0, fail_mask = 2'h0;
	logic [5:0][1:0] go_d = '0;
	logic [1:0][23:0] arr_row;
	logic [0:0] pg_plane, pl_last;
	logic [15:0] pg_col, col0;
	logic [255:0] cmds;
	logic [1:0] go_log[$];
	mps_op_t arr_op;
	int err_total = 0, num_checks = 0, cyc = 0, n_wr = 0, n_err = 0;

	mps_if #(.PLANES(2)) lk ();
	mps_host #(.PLANES(2)) i_mps_host (.aclk(aclk), .aresetn(aresetn), .ce(ce), .lk(lk.host),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	// short busy cut to two cycles to keep runs brief
	mps_device #(.PLANES(2), .T_SBSY_NS(16)) i_mps_device (.aclk(aclk), .aresetn(aresetn),
		.ce(ce), .lk(lk.dev), .cfg_overlap(cfg_overlap), .cfg_alt81(cfg_alt81),
		.cfg_cache(cfg_cache), .cfg_same_blk(cfg_same_blk), .cfg_same_page(cfg_same_page),
		.wp_n(wp_n), .arr_done(arr_done), .arr_fail(arr_fail), .arr_go(arr_go), .arr_op(arr_op),
		.arr_row(arr_row), .pg_wr(pg_wr), .pg_plane(pg_plane), .pg_col(pg_col),
		.pg_data(pg_data), .seq_err(seq_err));
	mps_link_chk #(.PLANES(2)) i_mps_link_chk (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.cle(lk.cle), .ale(lk.ale), .we(lk.we), .dq(lk.dq), .rdy(lk.rdy), .status(lk.status));

	always #4 aclk = ~aclk;

	// ----------------------------------------
	// array model and link monitor
	// ----------------------------------------
	always @(posedge aclk)
	begin
		cyc++;
		go_d <= {go_d[4:0], aresetn ? arr_go : 2'h0};
		arr_done <= go_d[5];
		arr_fail <= go_d[5] & fail_mask;
		if (aresetn && arr_go != 2'h0)
			go_log.push_back(arr_go);
		if (pg_wr === 1'b1 && n_wr == 0)
		begin
			wr0 = pg_data;
			col0 = pg_col;
		end
		if (pg_wr === 1'b1)
			pl_last = pg_plane;
		n_wr += int'(pg_wr === 1'b1);
		n_err += int'(seq_err === 1'b1);
		if (lk.we === 1'b1 && lk.cle === 1'b1)
			cmds[lk.dq] = 1'b1;
		if (cyc == 30000)
		begin
			err_total++;
			summarize();
		end
	end

	// ----------------------------------------
	// bus and compare tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
		awaddr <= {3'h0, a};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= {3'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	// two planes, two data bytes per program member
	function automatic logic [31:0] ctl(input logic [2:0] op, input logic c, input logic a);
		return 32'h0002_0201 | {26'h0, a, c, op, 1'b0};
	endfunction

	task automatic run(input logic [31:0] c, output logic [31:0] st);
		logic [1:0] r;
		int i;
		go_log.delete();
		n_wr = 0;
		n_err = 0;
		cmds = '0;
		i = 0;
		axi_wr(`MPS_OFF_CTRL, c, r);
		do
		begin
			axi_rd(`MPS_OFF_STAT, st, r);
			i++;
		end
		while (st[0] === 1'b1 && i < 400);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(`MPS_OFF_CTRL, d, r);
		chk("ctrl_reset", `MPS_CTRL_RST, d);
		axi_rd(`MPS_OFF_ROW, d, r);
		chk("row_reset", 32'h0, d);
		axi_rd(5'h1c, d, r);
		chk("unmapped_rresp", 32'h2, {30'h0, r});
		chk("unmapped_rdata", 32'h0, d);
		axi_wr(5'h1c, 32'hffff_ffff, r);
		chk("unmapped_bresp", 32'h2, {30'h0, r});
		chk("status_plane0", 32'he0, {24'h0, lk.status[0]});
		chk("status_plane1", 32'he0, {24'h0, lk.status[1]});
		wp_n <= 1'b0;
		repeat (2) @(posedge aclk);
		chk("status_wp", 32'h60, {24'h0, lk.status[1]});
		wp_n <= 1'b1;
		axi_wr(`MPS_OFF_ROW, 32'h0001_2345, r);
		axi_wr(`MPS_OFF_COL, 32'h0000_0010, r);
		axi_wr(`MPS_OFF_DATA, 32'h0000_00a5, r);
	endtask

	task automatic t_prog(input logic ovl, input logic [1:0] fm, input logic [15:0] ps);
		logic [31:0] st;
		logic [1:0] r;
		cfg_overlap <= ovl;
		cfg_same_blk <= ovl;
		cfg_same_page <= ovl;
		fail_mask <= fm;
		run(ctl(`MPS_HOP_PROG, 1'b0, 1'b0), st);
		chk("prog_state", 32'h2, {29'h0, st[2:0]});
		chk("go_pulses", ovl ? 32'h2 : 32'h1, 32'(go_log.size()));
		chk("go_first", ovl ? 32'h1 : 32'h3, {30'h0, go_log[0]});
		chk("row_plane0", 32'h01_2305, {8'h0, arr_row[0]});
		chk("row_plane1", 32'h01_2345, {8'h0, arr_row[1]});
		chk("page_bytes", 32'h4, 32'(n_wr));
		chk("first_byte", 32'ha5, {24'h0, wr0});
		chk("first_col", 32'h10, {16'h0, col0});
		chk("last_plane", 32'h1, {31'h0, pl_last});
		chk("confirms", 32'h1, {31'h0, cmds[`MPS_CMD_MPCONF] & cmds[`MPS_CMD_PCONF]});
		axi_rd(`MPS_OFF_PSTAT, st, r);
		chk("plane_status", {16'h0, ps}, st);
	endtask

	task automatic t_ops();
		logic [2:0] hop[3] = '{`MPS_HOP_ERASE, `MPS_HOP_READ, `MPS_HOP_CB};
		mps_op_t kind[3] = '{MPS_OP_ERASE, MPS_OP_READ, MPS_OP_CBPROG};
		logic [7:0] last[3] = '{`MPS_CMD_ECONF, `MPS_CMD_RCONF, `MPS_CMD_CBRCONF};
		logic [31:0] st;
		cfg_overlap <= 1'b0;
		fail_mask <= 2'h0;
		for (int k = 0; k < 3; k++)
		begin
			run(ctl(hop[k], 1'b0, 1'b0), st);
			chk("op_state", 32'h2, {29'h0, st[2:0]});
			chk("op_kind", {29'h0, kind[k]}, {29'h0, arr_op});
			chk("op_confirm", 32'h1, {31'h0, cmds[last[k]]});
		end
	endtask

	task automatic t_opts();
		logic [31:0] st;
		cfg_alt81 <= 1'b1;
		cfg_cache <= 1'b1;
		run(ctl(`MPS_HOP_PROG, 1'b0, 1'b1), st);
		chk("alt_cycle", 32'h1, {31'h0, cmds[`MPS_CMD_ALT]});
		chk("alt_refusals", 32'h0, 32'(n_err));
		run(ctl(`MPS_HOP_PROG, 1'b1, 1'b0), st);
		chk("cache_confirm", 32'h1, {31'h0, cmds[`MPS_CMD_CCONF]});
		chk("cache_state", 32'h2, {29'h0, st[2:0]});
		cfg_cache <= 1'b0;
		run(ctl(`MPS_HOP_PROG, 1'b1, 1'b0), st);
		chk("cache_refused", 32'h1, {31'h0, n_err != 0});
		chk("cache_no_launch", 32'h0, 32'(go_log.size()));
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_regs();
		t_prog(1'b0, 2'b10, 16'he1e0);
		t_prog(1'b1, 2'b01, 16'he2e1);
		t_ops();
		t_opts();
		summarize();
	end
endmodule
